/* File: hw/scht_pkg.sv */
package scht_pkg;

    // Core clock period
    localparam int CLK_PERIOD_NS = 8;

    // Off-time grows by one unit per code step, code 0 is one unit
    localparam int OFF_UNIT_NS = 2000;
    localparam int OFF_UNIT_CYC = (OFF_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Blanking intervals per select code, least times so round up
    localparam int BLANK0_NS = 250;
    localparam int BLANK1_NS = 500;
    localparam int BLANK2_NS = 1000;
    localparam int BLANK3_NS = 2000;
    localparam int BLANK0_CYC = (BLANK0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK1_CYC = (BLANK1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK2_CYC = (BLANK2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BLANK3_CYC = (BLANK3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Chopper counter width, holds 32 off-time units
    localparam int CNT_W = 14;

    // Register byte offsets
    localparam logic [7:0] REG_CFG_ONE = 8'h00;
    localparam logic [7:0] REG_CFG_TWO = 8'h04;
    localparam logic [7:0] REG_STEP = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;

    // Field positions
    localparam int BLANK_LSB = 0;
    localparam int OFF_LSB = 2;
    localparam int MIX_A_LSB = 0;
    localparam int MIX_B_LSB = 5;
    localparam int STEP_IDX_LSB = 0;
    localparam int STEP_EN_BIT = 8;
    localparam int STAT_A_LSB = 0;
    localparam int STAT_B_LSB = 2;

    // Reset values
    localparam logic [1:0] BLANK_RST = 2'h0;
    localparam logic [4:0] OFF_RST = 5'h00;
    localparam logic [4:0] MIX_RST = 5'h00;
    localparam logic [6:0] STEP_IDX_RST = 7'h39;

    // Sixteenth index 57 sits at zero degrees, so this offset maps index to angle
    localparam logic [6:0] ANGLE_OFS = 7'h07;

    typedef enum logic [1:0] {MODE_HIZ, MODE_DRIVE, MODE_FAST, MODE_SLOW} scht_mode_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } scht_bus_req_type;

    // Current reference in tenths of a percent of full_scale_current
    typedef struct packed {
        logic hiz;
        logic negative;
        logic [9:0] level;
    } scht_phase_cmd_type;

    // Quarter-wave magnitude, k steps of 5.625 degrees from zero
    function automatic logic [9:0] quarter_level(input logic [4:0] k);
        logic [9:0] v;
        v = 10'h000;
        unique case (k)
            5'h00: v = 10'h000;
            5'h01: v = 10'h062;
            5'h02: v = 10'h0c3;
            5'h03: v = 10'h122;
            5'h04: v = 10'h17f;
            5'h05: v = 10'h1d7;
            5'h06: v = 10'h22c;
            5'h07: v = 10'h27a;
            5'h08: v = 10'h2c3;
            5'h09: v = 10'h305;
            5'h0a: v = 10'h33f;
            5'h0b: v = 10'h372;
            5'h0c: v = 10'h39c;
            5'h0d: v = 10'h3bd;
            5'h0e: v = 10'h3d5;
            5'h0f: v = 10'h3e8;
            default: v = 10'h3e8;
        endcase
        return v;
    endfunction

endpackage

/* File: hw/scht_phase.sv */
`timescale 1ns/1ps
module scht_phase (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic run,
    input wire logic sense_trip,
    input wire logic [scht_pkg::CNT_W-1:0] blank_cyc,
    input wire logic [scht_pkg::CNT_W-1:0] off_cyc,
    input wire logic [scht_pkg::CNT_W-1:0] fast_cyc,
    output scht_pkg::scht_mode_type mode
);
    import scht_pkg::*;

    scht_mode_type mode_reg;
    scht_mode_type mode_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    assign mode = mode_reg;

    // Chopper sequence: drive, blank, trip, fast then slow decay, drive again
    always_comb begin
        mode_next = mode_reg;
        cnt_next = cnt_reg;
        if (!run) begin
            mode_next = MODE_HIZ;
            cnt_next = '0;
        end else begin
            unique case (mode_reg)
                MODE_HIZ: begin
                    mode_next = MODE_DRIVE;
                    cnt_next = '0;
                end
                MODE_DRIVE: begin
                    // Trips inside the blanking window are spikes, not current
                    if (cnt_reg >= blank_cyc && sense_trip) begin
                        mode_next = (fast_cyc != '0) ? MODE_FAST : MODE_SLOW;
                        cnt_next = {{(CNT_W-1){1'b0}}, 1'b1};
                    end else if (cnt_reg < blank_cyc) begin
                        cnt_next = cnt_reg + 1'b1;
                    end
                end
                MODE_FAST, MODE_SLOW: begin
                    // Off phase lasts off_cyc cycles, the first fast_cyc of them fast
                    if (cnt_reg >= off_cyc) begin
                        mode_next = MODE_DRIVE;
                        cnt_next = '0;
                    end else begin
                        cnt_next = cnt_reg + 1'b1;
                        // Once slow, stay slow: a fast count raised mid-period must not restart fast
                        if (mode_reg == MODE_SLOW || cnt_reg >= fast_cyc) begin
                            mode_next = MODE_SLOW;
                        end else begin
                            mode_next = MODE_FAST;
                        end
                    end
                end
            endcase
        end
    end

    // State registers
    always_ff @(posedge core_clk) begin
        if (srst) begin
            mode_reg <= MODE_HIZ;
            cnt_reg <= '0;
        end else begin
            mode_reg <= mode_next;
            cnt_reg <= cnt_next;
        end
    end

    // Helper count of off cycles seen, only the checks read it
    logic [CNT_W-1:0] off_len_reg;
    always_ff @(posedge core_clk) begin
        if (srst) begin
            off_len_reg <= '0;
        end else if (mode_reg == MODE_FAST || mode_reg == MODE_SLOW) begin
            off_len_reg <= off_len_reg + 1'b1;
        end else begin
            off_len_reg <= '0;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_trip_taken;
        run && mode_reg == MODE_DRIVE && cnt_reg >= blank_cyc && sense_trip;
    endsequence

    sequence s_off_entered;
        ##1 (mode_reg == MODE_FAST || mode_reg == MODE_SLOW) && off_len_reg == '0;
    endsequence

    a_blank_masks_trip: assert property (
        run && mode_reg == MODE_DRIVE && cnt_reg < blank_cyc && $stable(run)
        |=> mode_reg == MODE_DRIVE || !run)
        else $error("trip acted inside blanking window");

    a_trip_starts_off: assert property (
        s_trip_taken |-> s_off_entered)
        else $error("sense trip did not start off-time");

    a_off_length_exact: assert property (
        (mode_reg == MODE_FAST || mode_reg == MODE_SLOW) && run && $stable(off_cyc)
        ##1 mode_reg == MODE_DRIVE |-> off_len_reg == $past(off_cyc))
        else $error("off-time length wrong");

    a_fast_fraction_held: assert property (
        mode_reg == MODE_FAST |-> off_len_reg < $past(fast_cyc))
        else $error("fast decay beyond programmed fraction");

    a_slow_after_fast: assert property (
        mode_reg == MODE_SLOW && run |=> mode_reg != MODE_FAST)
        else $error("fast decay after slow decay");

endmodule

/* File: hw/scht_top.sv */
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/1ps
// What this block does
// - In sixteenth-step mode index 63 commands phase A 55.6% and B 83.1%, index 64 commands 63.4% and 77.3%.
// - A two-bit blanking select in config one sets how long the sense comparator is ignored after drive starts.
// - A five-bit off-time code in config one programs the chopping off-time.
// - The off-time is 2 us for code 0, plus 2 us per code step, up to 64 us for code 31.
// - Each phase has its own five-bit decay-mix code in config two setting its share of fast decay.
// - The fast share is the low four bits times 6.25 percent, and any code with the top bit set is all fast.
module scht_top #(
    parameter int OFF_UNIT_CYCLES = scht_pkg::OFF_UNIT_CYC
) (
    input wire logic core_clk,
    input wire logic srst,
    input scht_pkg::scht_bus_req_type bus_req,
    output logic [31:0] rdata,
    input wire logic sense_trip_a,
    input wire logic sense_trip_b,
    output scht_pkg::scht_phase_cmd_type phase_a_cmd,
    output scht_pkg::scht_phase_cmd_type phase_b_cmd,
    output scht_pkg::scht_mode_type phase_a_mode,
    output scht_pkg::scht_mode_type phase_b_mode
);
    import scht_pkg::*;

    // Off-time in cycles from the five-bit code
    function automatic logic [CNT_W-1:0] off_cycles(input logic [4:0] code);
        int total;
        total = (int'(code) + 1) * OFF_UNIT_CYCLES;
        return CNT_W'(total);
    endfunction

    // Fast-decay cycles: sixteenths of the off-time, or all of it
    function automatic logic [CNT_W-1:0] fast_cycles(input logic [CNT_W-1:0] off,
                                                      input logic [4:0] mix);
        logic [CNT_W+3:0] prod;
        prod = {4'h0, off} * {{CNT_W{1'b0}}, mix[3:0]};
        return mix[4] ? off : prod[CNT_W+3:4];
    endfunction

    // Blanking cycles from select code
    function automatic logic [CNT_W-1:0] blank_cycles(input logic [1:0] sel);
        logic [CNT_W-1:0] v;
        v = '0;
        unique case (sel)
            2'h0: v = CNT_W'(BLANK0_CYC);
            2'h1: v = CNT_W'(BLANK1_CYC);
            2'h2: v = CNT_W'(BLANK2_CYC);
            2'h3: v = CNT_W'(BLANK3_CYC);
        endcase
        return v;
    endfunction

    // Signed phase reference from a quarter-wave magnitude
    function automatic scht_phase_cmd_type make_cmd(input logic [4:0] k, input logic neg);
        scht_phase_cmd_type c;
        c.level = quarter_level(k);
        c.negative = neg && (c.level != 10'h000);
        c.hiz = (c.level == 10'h000);
        return c;
    endfunction

    // Software registers
    logic [1:0] blanking_select_reg;
    logic [1:0] blanking_select_next;
    logic [4:0] off_time_code_reg;
    logic [4:0] off_time_code_next;
    logic [4:0] decay_mix_phase_a_reg;
    logic [4:0] decay_mix_phase_a_next;
    logic [4:0] decay_mix_phase_b_reg;
    logic [4:0] decay_mix_phase_b_next;
    logic [6:0] step_index_reg;
    logic [6:0] step_index_next;
    logic step_enable_reg;
    logic step_enable_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    // Derived timing, registered so the chopper sees settled counts
    logic [CNT_W-1:0] blank_cyc_reg;
    logic [CNT_W-1:0] blank_cyc_next;
    logic [CNT_W-1:0] off_cyc_reg;
    logic [CNT_W-1:0] off_cyc_next;
    logic [CNT_W-1:0] fast_a_reg;
    logic [CNT_W-1:0] fast_a_next;
    logic [CNT_W-1:0] fast_b_reg;
    logic [CNT_W-1:0] fast_b_next;

    // Phase references
    scht_phase_cmd_type cmd_a_reg;
    scht_phase_cmd_type cmd_a_next;
    scht_phase_cmd_type cmd_b_reg;
    scht_phase_cmd_type cmd_b_next;

    scht_mode_type mode_a;
    scht_mode_type mode_b;

    logic [5:0] angle;
    logic [1:0] quadrant;
    logic [4:0] k_lo;
    logic [4:0] k_hi;

    assign rdata = rdata_reg;
    assign phase_a_cmd = cmd_a_reg;
    assign phase_b_cmd = cmd_b_reg;
    assign phase_a_mode = mode_a;
    assign phase_b_mode = mode_b;

    // Register writes and read data; unmapped reads return zero
    always_comb begin
        blanking_select_next = blanking_select_reg;
        off_time_code_next = off_time_code_reg;
        decay_mix_phase_a_next = decay_mix_phase_a_reg;
        decay_mix_phase_b_next = decay_mix_phase_b_reg;
        step_index_next = step_index_reg;
        step_enable_next = step_enable_reg;
        rdata_next = 32'h0000_0000;
        if (bus_req.wr) begin
            unique case (bus_req.addr)
                REG_CFG_ONE: begin
                    blanking_select_next = bus_req.wdata[BLANK_LSB +: 2];
                    off_time_code_next = bus_req.wdata[OFF_LSB +: 5];
                end
                REG_CFG_TWO: begin
                    decay_mix_phase_a_next = bus_req.wdata[MIX_A_LSB +: 5];
                    decay_mix_phase_b_next = bus_req.wdata[MIX_B_LSB +: 5];
                end
                REG_STEP: begin
                    step_index_next = bus_req.wdata[STEP_IDX_LSB +: 7];
                    step_enable_next = bus_req.wdata[STEP_EN_BIT];
                end
                default: begin
                end
            endcase
        end
        if (bus_req.rd) begin
            unique case (bus_req.addr)
                REG_CFG_ONE: begin
                    rdata_next[BLANK_LSB +: 2] = blanking_select_reg;
                    rdata_next[OFF_LSB +: 5] = off_time_code_reg;
                end
                REG_CFG_TWO: begin
                    rdata_next[MIX_A_LSB +: 5] = decay_mix_phase_a_reg;
                    rdata_next[MIX_B_LSB +: 5] = decay_mix_phase_b_reg;
                end
                REG_STEP: begin
                    rdata_next[STEP_IDX_LSB +: 7] = step_index_reg;
                    rdata_next[STEP_EN_BIT] = step_enable_reg;
                end
                REG_STATUS: begin
                    rdata_next[STAT_A_LSB +: 2] = mode_a;
                    rdata_next[STAT_B_LSB +: 2] = mode_b;
                end
                default: begin
                end
            endcase
        end
    end

    // Register bank
    always_ff @(posedge core_clk) begin
        if (srst) begin
            blanking_select_reg <= BLANK_RST;
            off_time_code_reg <= OFF_RST;
            decay_mix_phase_a_reg <= MIX_RST;
            decay_mix_phase_b_reg <= MIX_RST;
            step_index_reg <= STEP_IDX_RST;
            step_enable_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            blanking_select_reg <= blanking_select_next;
            off_time_code_reg <= off_time_code_next;
            decay_mix_phase_a_reg <= decay_mix_phase_a_next;
            decay_mix_phase_b_reg <= decay_mix_phase_b_next;
            step_index_reg <= step_index_next;
            step_enable_reg <= step_enable_next;
            rdata_reg <= rdata_next;
        end
    end

    // Index to angle: index 57 is zero degrees, 64 entries per turn
    assign angle = 6'(step_index_reg + ANGLE_OFS);
    assign quadrant = angle[5:4];
    assign k_lo = {1'b0, angle[3:0]};
    assign k_hi = 5'h10 - k_lo;

    // Sine to phase A and cosine to phase B, by quadrant symmetry
    always_comb begin
        cmd_a_next = make_cmd(k_lo, 1'b0);
        cmd_b_next = make_cmd(k_hi, 1'b0);
        unique case (quadrant)
            2'h0: begin
                cmd_a_next = make_cmd(k_lo, 1'b0);
                cmd_b_next = make_cmd(k_hi, 1'b0);
            end
            2'h1: begin
                cmd_a_next = make_cmd(k_hi, 1'b0);
                cmd_b_next = make_cmd(k_lo, 1'b1);
            end
            2'h2: begin
                cmd_a_next = make_cmd(k_lo, 1'b1);
                cmd_b_next = make_cmd(k_hi, 1'b1);
            end
            2'h3: begin
                cmd_a_next = make_cmd(k_hi, 1'b1);
                cmd_b_next = make_cmd(k_lo, 1'b0);
            end
        endcase
        blank_cyc_next = blank_cycles(blanking_select_reg);
        off_cyc_next = off_cycles(off_time_code_reg);
        fast_a_next = fast_cycles(off_cyc_reg, decay_mix_phase_a_reg);
        fast_b_next = fast_cycles(off_cyc_reg, decay_mix_phase_b_reg);
    end

    // Derived values; one cycle behind the registers, the fast counts two behind the off-time code via off_cyc_reg, fine at chopper rates
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cmd_a_reg <= '0;
            cmd_b_reg <= '0;
            // Decoded reset values, so the counts agree with the fields from the first edge
            blank_cyc_reg <= blank_cycles(BLANK_RST);
            off_cyc_reg <= off_cycles(OFF_RST);
            fast_a_reg <= '0;
            fast_b_reg <= '0;
        end else begin
            cmd_a_reg <= cmd_a_next;
            cmd_b_reg <= cmd_b_next;
            blank_cyc_reg <= blank_cyc_next;
            off_cyc_reg <= off_cyc_next;
            fast_a_reg <= fast_a_next;
            fast_b_reg <= fast_b_next;
        end
    end

    // A phase at zero current floats and does not chop
    scht_phase u_phase_a (
        .core_clk(core_clk),
        .srst(srst),
        .run(step_enable_reg && !cmd_a_reg.hiz),
        .sense_trip(sense_trip_a),
        .blank_cyc(blank_cyc_reg),
        .off_cyc(off_cyc_reg),
        .fast_cyc(fast_a_reg),
        .mode(mode_a)
    );

    scht_phase u_phase_b (
        .core_clk(core_clk),
        .srst(srst),
        .run(step_enable_reg && !cmd_b_reg.hiz),
        .sense_trip(sense_trip_b),
        .blank_cyc(blank_cyc_reg),
        .off_cyc(off_cyc_reg),
        .fast_cyc(fast_b_reg),
        .mode(mode_b)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    a_table_index_63: assert property (
        step_index_reg == 7'h3f |=> cmd_a_reg.level == 10'd556 && cmd_b_reg.level == 10'd831
        && !cmd_a_reg.negative && !cmd_b_reg.negative)
        else $error("index 63 reference wrong");

    a_table_index_64: assert property (
        step_index_reg == 7'h40 |=> cmd_a_reg.level == 10'd634 && cmd_b_reg.level == 10'd773)
        else $error("index 64 reference wrong");

    a_off_code_decode: assert property (
        $stable(off_time_code_reg) |=>
        off_cyc_reg == CNT_W'((int'($past(off_time_code_reg)) + 1) * OFF_UNIT_CYCLES))
        else $error("off-time decode wrong");

    a_mix_full_fast: assert property (
        decay_mix_phase_a_reg[4] && $stable(decay_mix_phase_a_reg) |=> fast_a_reg == $past(off_cyc_reg))
        else $error("top mix bit not all fast");

    a_blank_decode: assert property (
        $stable(blanking_select_reg) && blanking_select_reg == 2'h3 |=> blank_cyc_reg == CNT_W'(BLANK3_CYC))
        else $error("blanking decode wrong");

endmodule

/* File: bench/scht_bridge_model.sv */
`timescale 1ns/1ps
module scht_bridge_model (
    input wire logic core_clk,
    input wire logic srst,
    input scht_pkg::scht_mode_type mode,
    input scht_pkg::scht_phase_cmd_type cmd,
    input wire logic [11:0] rise_step,
    output logic sense_trip
);
    import scht_pkg::*;
    logic [11:0] current_reg;
    logic [11:0] current_next;

    // Winding current follows the bridge state; fast decay sheds it much quicker than slow
    always_comb begin
        current_next = current_reg;
        case (mode)
            MODE_DRIVE: current_next = (current_reg > 12'hfa0 - rise_step) ? 12'hfa0 :
                current_reg + rise_step;
            MODE_FAST: current_next = current_reg >> 1;
            MODE_SLOW: current_next = (current_reg == 12'h000) ? 12'h000 : current_reg - 12'h001;
            default: current_next = 12'h000;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            current_reg <= 12'h000;
        end else begin
            current_reg <= current_next;
        end
    end

    // A floating phase carries no current, so its comparator never trips
    assign sense_trip = !cmd.hiz && (current_reg >= {2'h0, cmd.level});
endmodule

/* File: bench/test_scht_top.sv */
`timescale 1ns/1ps
module test_scht_top;
    import scht_pkg::*;
    // Short off unit keeps the longest off period at 128 cycles
    localparam int UNIT = 4;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    scht_bus_req_type bus_req = '0;
    logic [31:0] rdata;
    logic sense_trip_a;
    logic sense_trip_b;
    scht_phase_cmd_type phase_a_cmd;
    scht_phase_cmd_type phase_b_cmd;
    scht_mode_type phase_a_mode;
    scht_mode_type phase_b_mode;
    logic [11:0] rise_a = 12'h3e8;
    logic [11:0] rise_b = 12'h3e8;
    logic [31:0] expect_q[$];
    logic rd_seen = 1'b0;
    logic [7:0] seed = 8'h5d;
    int n_fail = 0;
    int n_compared = 0;

    scht_top #(.OFF_UNIT_CYCLES(UNIT)) i_dut (.core_clk(core_clk), .srst(srst),
        .bus_req(bus_req), .rdata(rdata), .sense_trip_a(sense_trip_a),
        .sense_trip_b(sense_trip_b), .phase_a_cmd(phase_a_cmd), .phase_b_cmd(phase_b_cmd),
        .phase_a_mode(phase_a_mode), .phase_b_mode(phase_b_mode));
    scht_bridge_model i_bridge_a (.core_clk(core_clk), .srst(srst), .mode(phase_a_mode),
        .cmd(phase_a_cmd), .rise_step(rise_a), .sense_trip(sense_trip_a));
    scht_bridge_model i_bridge_b (.core_clk(core_clk), .srst(srst), .mode(phase_b_mode),
        .cmd(phase_b_cmd), .rise_step(rise_b), .sense_trip(sense_trip_b));

    // Clock at 125 MHz
    initial begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic summarize();
        $display("compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // Each read answer is matched with the oldest note the driver left
    always @(posedge core_clk) begin
        if (rd_seen && expect_q.size() > 0) begin
            check(rdata, expect_q.pop_front(), "read data");
        end
        rd_seen <= bus_req.rd;
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic bus_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        expect_q.push_back(exp);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
    endtask

    function automatic scht_mode_type mode_of(input bit ph);
        return ph ? phase_b_mode : phase_a_mode;
    endfunction

    // Skips to a fresh drive start, since a period cut by a config write is not clean
    task automatic phase_cycle(input bit ph, output int drv, output int fst, output int slw);
        int guard;
        drv = 0;
        fst = 0;
        slw = 0;
        guard = 0;
        while (mode_of(ph) === MODE_DRIVE && guard < 2000) begin tick(); guard++; end
        while (mode_of(ph) !== MODE_DRIVE && guard < 2000) begin tick(); guard++; end
        while (mode_of(ph) === MODE_DRIVE && guard < 2000) begin tick(); drv++; guard++; end
        while (mode_of(ph) === MODE_FAST && guard < 2000) begin tick(); fst++; guard++; end
        while (mode_of(ph) === MODE_SLOW && guard < 2000) begin tick(); slw++; guard++; end
        check(mode_of(ph), MODE_DRIVE, "drive after off");
    endtask

    function automatic int fast_of(input int o, input logic [4:0] m);
        return m[4] ? o : o * int'(m[3:0]) / 16;
    endfunction

    task automatic chop_case(input logic [1:0] sel, input logic [4:0] off,
        input logic [4:0] ma, input logic [4:0] mb);
        int da, fa, sa, db, fb, sb, o, blank;
        o = (int'(off) + 1) * UNIT;
        blank = (sel == 2'h0) ? BLANK0_CYC : (sel == 2'h1) ? BLANK1_CYC :
            (sel == 2'h2) ? BLANK2_CYC : BLANK3_CYC;
        bus_write(REG_CFG_ONE, {25'h0, off, sel});
        bus_write(REG_CFG_TWO, {22'h0, mb, ma});
        fork
            phase_cycle(1'b0, da, fa, sa);
            phase_cycle(1'b1, db, fb, sb);
        join
        check(da, blank + 1, "drive length a");
        check(db, blank + 1, "drive length b");
        check(fa, fast_of(o, ma), "fast length a");
        check(fb, fast_of(o, mb), "fast length b");
        check(fa + sa, o, "off length a");
        check(fb + sb, o, "off length b");
    endtask

    // Main sequence: reset state, phase table, chopper timing, slow ramp, disable
    initial begin
        logic [7:0] r0, r1;
        int d, f, s;
        repeat (3) @(posedge core_clk);
        srst <= 1'b0;
        repeat (2) tick();
        check(phase_a_cmd, 12'h800, "rest cmd a");
        check(phase_b_cmd, 12'h3e8, "rest cmd b");
        check(phase_a_mode, MODE_HIZ, "rest mode a");
        bus_read(REG_CFG_ONE, 32'h0);
        bus_read(REG_CFG_TWO, 32'h0);
        bus_read(REG_STEP, 32'h39);
        bus_read(REG_STATUS, 32'h0);
        bus_write(8'h10, 32'hffffffff);
        bus_read(8'h10, 32'h0);
        bus_write(REG_STEP, 32'h140);
        repeat (2) tick();
        check(phase_a_cmd, 12'h27a, "index 64 a");
        check(phase_b_cmd, 12'h305, "index 64 b");
        bus_write(REG_STEP, 32'h13f);
        repeat (2) tick();
        check(phase_a_cmd, 12'h22c, "index 63 a");
        check(phase_b_cmd, 12'h33f, "index 63 b");
        bus_read(REG_STEP, 32'h13f);
        for (int i = 0; i < 4; i++) begin
            r0 = lfsr(seed);
            r1 = lfsr(r0);
            seed = lfsr(r1);
            chop_case(i[1:0], r0[4:0], r1[4:0], seed[4:0]);
        end
        chop_case(2'h0, 5'h00, 5'h00, 5'h10);
        chop_case(2'h1, 5'h1f, 5'h0f, 5'h01);
        // A slow current ramp must keep the phase driving well past blanking
        bus_write(REG_CFG_ONE, 32'h7c);
        bus_write(REG_CFG_TWO, 32'h3ff);
        rise_a <= 12'h002;
        phase_cycle(1'b0, d, f, s);
        phase_cycle(1'b0, d, f, s);
        check(d, 556 / 2 + 1, "drive held until trip");
        bus_write(REG_STEP, 32'h03f);
        repeat (2) tick();
        check(phase_a_mode, MODE_HIZ, "disabled a");
        check(phase_b_mode, MODE_HIZ, "disabled b");
        bus_read(REG_STATUS, 32'h0);
        // Negative half of the turn, reached by the same table symmetry
        bus_write(REG_STEP, 32'h021);
        repeat (2) tick();
        check(phase_a_cmd, 12'h6c3, "index 33 a");
        check(phase_b_cmd, 12'h6c3, "index 33 b");
        bus_write(REG_STEP, 32'h029);
        repeat (2) tick();
        check(phase_a_cmd, 12'h7e8, "index 41 a");
        check(phase_b_cmd, 12'h800, "index 41 b");
        repeat (3) tick();
        summarize();
    end

    // Whole run needs well under 20k cycles, so this only trips on a hang
    initial begin
        #(60000 * 8);
        n_fail++;
        $display("unexpected at %0t: watchdog expired", $time);
        summarize();
    end
endmodule
